// File: verilog/ddf_frontend.sv
// two-decoder front end, per-thread queue and two-port in-order issue
// assumes fetch presents up to two predecoded instructions per thread
`default_nettype none

module ddf_frontend #(
  parameter int unsigned QDEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fetch, per thread: two slots, attributes packed per slot
  input wire logic [1:0] f_valid0,
  input wire logic [1:0] f_valid1,
  input wire logic [7:0] f_unit0,
  input wire logic [7:0] f_unit1,
  input wire logic [9:0] f_len0,
  input wire logic [9:0] f_len1,
  input wire logic [5:0] f_pfx0,
  input wire logic [5:0] f_pfx1,
  input wire logic [1:0] f_x870,
  input wire logic [1:0] f_x871,
  input wire logic [1:0] f_rom0,
  input wire logic [1:0] f_rom1,
  input wire logic [1:0] f_simd640,
  input wire logic [1:0] f_simd641,
  input wire logic [1:0] f_load0,
  input wire logic [1:0] f_load1,
  input wire logic [1:0] f_unsafe0,
  input wire logic [1:0] f_unsafe1,
  input wire logic [3:0] f_addr_lo0,
  input wire logic [3:0] f_addr_lo1,
  input wire logic prefetch_ready,
  // fetch consumption
  output logic [1:0] f_taken0,
  output logic [1:0] f_taken1,
  output logic dec_thread,
  // issue ports
  output logic [1:0] iss_valid,
  output logic [1:0] iss_thread,
  output logic [ddf_pkg::UNIT_BITS-1:0] iss_sel0,
  output logic [ddf_pkg::UNIT_BITS-1:0] iss_sel1,
  output logic [1:0] iss_wide,
  output logic [1:0] iss_zero_lu,
  output logic rom_busy,
  output logic fe_stall
);
  initial begin
    if (QDEPTH < 2 || QDEPTH > 16) $error("QDEPTH must be 2..16");
  end

  localparam int AW = $clog2(QDEPTH);
  typedef struct packed {
    logic [3:0] unit;
    logic simd64;
    logic load;
    logic unsafe_;
  } ddf_ent_s;

  logic [1:0] rst_sync_q;
  logic rst_ok;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_ok = rst_sync_q[1];

  // fetch pins pass two flops
  logic [1:0] s_v0_a, s_v0_b, s_v1_a, s_v1_b, s_x0_a, s_x0_b, s_x1_a, s_x1_b;
  logic [1:0] s_r0_a, s_r0_b, s_r1_a, s_r1_b, s_s0_a, s_s0_b, s_s1_a, s_s1_b;
  logic [1:0] s_l0_a, s_l0_b, s_l1_a, s_l1_b, s_u0_a, s_u0_b, s_u1_a, s_u1_b;
  logic [7:0] s_un0_a, s_un0_b, s_un1_a, s_un1_b;
  logic [9:0] s_ln0_a, s_ln0_b, s_ln1_a, s_ln1_b;
  logic [5:0] s_p0_a, s_p0_b, s_p1_a, s_p1_b;
  logic [3:0] s_a0_a, s_a0_b, s_a1_a, s_a1_b;
  logic s_pr_a, s_pr_b;
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      {s_v0_a, s_v0_b, s_v1_a, s_v1_b, s_x0_a, s_x0_b, s_x1_a, s_x1_b} <= '0;
      {s_r0_a, s_r0_b, s_r1_a, s_r1_b, s_s0_a, s_s0_b, s_s1_a, s_s1_b} <= '0;
      {s_l0_a, s_l0_b, s_l1_a, s_l1_b, s_u0_a, s_u0_b, s_u1_a, s_u1_b} <= '0;
      {s_un0_a, s_un0_b, s_un1_a, s_un1_b, s_ln0_a, s_ln0_b, s_ln1_a, s_ln1_b} <= '0;
      {s_p0_a, s_p0_b, s_p1_a, s_p1_b, s_a0_a, s_a0_b, s_a1_a, s_a1_b} <= '0;
      {s_pr_a, s_pr_b} <= '0;
    end else begin
      {s_v0_a, s_v1_a, s_x0_a, s_x1_a} <= {f_valid0, f_valid1, f_x870, f_x871};
      {s_v0_b, s_v1_b, s_x0_b, s_x1_b} <= {s_v0_a, s_v1_a, s_x0_a, s_x1_a};
      {s_r0_a, s_r1_a, s_s0_a, s_s1_a} <= {f_rom0, f_rom1, f_simd640, f_simd641};
      {s_r0_b, s_r1_b, s_s0_b, s_s1_b} <= {s_r0_a, s_r1_a, s_s0_a, s_s1_a};
      {s_l0_a, s_l1_a, s_u0_a, s_u1_a} <= {f_load0, f_load1, f_unsafe0, f_unsafe1};
      {s_l0_b, s_l1_b, s_u0_b, s_u1_b} <= {s_l0_a, s_l1_a, s_u0_a, s_u1_a};
      {s_un0_a, s_un1_a, s_ln0_a, s_ln1_a} <= {f_unit0, f_unit1, f_len0, f_len1};
      {s_un0_b, s_un1_b, s_ln0_b, s_ln1_b} <= {s_un0_a, s_un1_a, s_ln0_a, s_ln1_a};
      {s_p0_a, s_p1_a, s_a0_a, s_a1_a} <= {f_pfx0, f_pfx1, f_addr_lo0, f_addr_lo1};
      {s_p0_b, s_p1_b, s_a0_b, s_a1_b} <= {s_p0_a, s_p1_a, s_a0_a, s_a1_a};
      s_pr_a <= prefetch_ready;
      s_pr_b <= s_pr_a;
    end
  end

  // per-thread queue partitions
  ddf_ent_s q_mem [2][QDEPTH];
  logic [AW-1:0] q_rd_q [2];
  logic [AW-1:0] q_wr_q [2];
  logic [AW:0] q_cnt_q [2];

  // decode-side thread choice and slot selection
  logic th_q;
  logic [1:0] sv, sx, sr, ss, sl, su;
  logic [7:0] sun;
  logic [9:0] sln;
  logic [5:0] sp;
  logic [3:0] sa;
  logic [1:0] rdy;
  logic [1:0] blind_q [2];
  always_comb begin
    rdy[0] = s_v0_b[0] && blind_q[0] == 2'd0 && (q_cnt_q[0] <= (AW+1)'(QDEPTH - 2));
    rdy[1] = s_v1_b[0] && blind_q[1] == 2'd0 && (q_cnt_q[1] <= (AW+1)'(QDEPTH - 2));
  end

  // decoder slot qualifiers
  logic [1:0] dec_go;
  logic rom_req, long_or_pfx, pair_cross, byte_block;
  logic [2:0] rom_cnt_q;
  logic hold_q;
  logic dth;
  always_comb begin
    dth = (rdy[0] && rdy[1]) ? th_q : rdy[1];
    sv = dth ? s_v1_b : s_v0_b;
    sx = dth ? s_x1_b : s_x0_b;
    sr = dth ? s_r1_b : s_r0_b;
    ss = dth ? s_s1_b : s_s0_b;
    sl = dth ? s_l1_b : s_l0_b;
    su = dth ? s_u1_b : s_u0_b;
    sun = dth ? s_un1_b : s_un0_b;
    sln = dth ? s_ln1_b : s_ln0_b;
    sp = dth ? s_p1_b : s_p0_b;
    sa = dth ? s_a1_b : s_a0_b;
    long_or_pfx = (int'(sln[4:0]) > ddf_pkg::LONG_INSN_BYTES)
      || (int'(sp[2:0]) > ddf_pkg::MAX_PREFIXES);
    rom_req = sv[0] && (sr[0] || long_or_pfx);
    pair_cross = (7'(sa) + 7'(sln[4:0]) + 7'(sln[9:5])) > 7'(ddf_pkg::LINE_BYTES);
    dec_go = 2'b00;
    if ((rdy != 2'b00) && !byte_block && !hold_q && rom_cnt_q == 3'd0) begin
      dec_go[0] = sv[0];
      // slot 1 only with a plain, non-jump, non-x87-collision first slot
      dec_go[1] = sv[1] && !rom_req && !(sun[3:0] == 4'(ddf_pkg::DDF_U_JUMP))
        && !(sx[0] && sx[1])
        && !sr[1] && !((int'(sln[9:5]) > ddf_pkg::LONG_INSN_BYTES)
        || (int'(sp[5:3]) > ddf_pkg::MAX_PREFIXES));
    end
  end

  // synced fetch pins lag the taken pulse: skip the thread until fresh slots arrive
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      blind_q[0] <= 2'd0;
      blind_q[1] <= 2'd0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (dec_go != 2'b00 && dth == 1'(i)) blind_q[i] <= 2'd2;
        else if (blind_q[i] != 2'd0) blind_q[i] <= blind_q[i] - 2'd1;
      end
    end
  end

  // rom transfer delay, decoder 0 only
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) rom_cnt_q <= 3'd0;
    else if (rom_cnt_q != 3'd0) rom_cnt_q <= rom_cnt_q - 3'd1;
    else if (dec_go[0] && rom_req) rom_cnt_q <= 3'(ddf_pkg::ROM_DELAY_CYCLES);
  end

  // 16-byte boundary hold
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) hold_q <= 1'b0;
    else hold_q <= (dec_go == 2'b11) && pair_cross;
  end

  // sliding byte window
  logic [9:0] win_q [ddf_pkg::BYTE_WINDOW_CYCLES];
  logic [9:0] win_sum, now_bytes;
  always_comb begin
    now_bytes = (dec_go[0] ? 10'(sln[4:0]) : 10'd0) + (dec_go[1] ? 10'(sln[9:5]) : 10'd0);
    win_sum = 10'd0;
    for (int i = 0; i < ddf_pkg::BYTE_WINDOW_CYCLES - 1; i++) win_sum = win_sum + win_q[i];
    byte_block = (int'(win_sum) > ddf_pkg::BYTE_WINDOW_LIMIT) && !s_pr_b;
  end
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      for (int i = 0; i < ddf_pkg::BYTE_WINDOW_CYCLES; i++) win_q[i] <= 10'd0;
    end else begin
      win_q[0] <= now_bytes;
      for (int i = 1; i < ddf_pkg::BYTE_WINDOW_CYCLES; i++) win_q[i] <= win_q[i-1];
    end
  end

  // issue: oldest two of chosen thread, with cross-thread fill
  ddf_ent_s h0, h1, hx;
  logic ith;
  logic [1:0] irdy;
  logic [1:0] pop [2];
  logic m_legal0, m_legal1, m_w0, m_w1, m_legalx, m_wx;
  logic [ddf_pkg::UNIT_BITS-1:0] m_sel0, m_sel1, m_selx;
  logic [3:0] u_port0, u_port1;
  logic use_x;
  always_comb begin
    irdy[0] = q_cnt_q[0] != '0;
    irdy[1] = q_cnt_q[1] != '0;
    ith = (irdy[0] && irdy[1]) ? ~th_q : irdy[1];
    h0 = q_mem[ith][q_rd_q[ith]];
    h1 = q_mem[ith][AW'(q_rd_q[ith] + AW'(1))];
    hx = q_mem[~ith][q_rd_q[~ith]];
  end

  ddf_port_map u_map0 (
    .unit(h0.unit),
    .port1(1'b0),
    .simd64(h0.simd64),
    .fadd_load(h0.load),
    .legal(m_legal0),
    .sel(m_sel0),
    .wide(m_w0)
  );
  ddf_port_map u_map1 (
    .unit(use_x ? hx.unit : h1.unit),
    .port1(1'b1),
    .simd64(use_x ? hx.simd64 : h1.simd64),
    .fadd_load(use_x ? hx.load : h1.load),
    .legal(m_legal1),
    .sel(m_sel1),
    .wide(m_w1)
  );
  ddf_port_map u_mapx (
    .unit(h0.unit),
    .port1(1'b1),
    .simd64(h0.simd64),
    .fadd_load(h0.load),
    .legal(m_legalx),
    .sel(m_selx),
    .wide(m_wx)
  );

  logic g0, g1, swap, p0_unsafe;
  always_comb begin
    use_x = irdy[~ith] && (q_cnt_q[ith] < (AW+1)'(2) || h0.unsafe_);
    swap = !m_legal0 && m_legalx;
    g0 = irdy[ith];
    p0_unsafe = h0.unsafe_;
    g1 = (use_x || q_cnt_q[ith] >= (AW+1)'(2)) && m_legal1 && !swap
      && !(h0.unit == 4'(ddf_pkg::DDF_U_FADD) && h0.load);
    pop[0] = 2'b00;
    pop[1] = 2'b00;
    if (g0) pop[ith][0] = 1'b1;
    if (g1) begin
      if (use_x) pop[~ith][0] = 1'b1;
      else pop[ith][1] = 1'b1;
    end
  end

  // queue update, at most two writes per cycle
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_q
      logic [1:0] wr;
      logic [1:0] np;
      ddf_ent_s e0, e1;
      assign wr = (dth == 1'(t)) ? dec_go : 2'b00;
      assign np = {1'b0, pop[t][0]} + {1'b0, pop[t][1]};
      assign e0 = '{unit: sun[3:0], simd64: ss[0], load: sl[0], unsafe_: su[0]};
      assign e1 = '{unit: sun[7:4], simd64: ss[1], load: sl[1], unsafe_: su[1]};
      always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
          q_rd_q[t] <= '0;
          q_wr_q[t] <= '0;
          q_cnt_q[t] <= '0;
        end else begin
          q_rd_q[t] <= AW'(q_rd_q[t] + AW'(np));
          q_wr_q[t] <= AW'(q_wr_q[t] + AW'(wr[0]) + AW'(wr[1]));
          q_cnt_q[t] <= (AW+1)'(q_cnt_q[t] + (AW+1)'(wr[0]) + (AW+1)'(wr[1]) - (AW+1)'(np));
        end
      end
      always_ff @(posedge clk) begin
        if (wr[0]) q_mem[t][q_wr_q[t]] <= e0;
        if (wr[1]) q_mem[t][AW'(q_wr_q[t] + AW'(1))] <= e1;
      end
    end
  endgenerate

  // fairness toggle
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) th_q <= 1'b0;
    else if ((dec_go != 2'b00) || g0) th_q <= ~th_q;
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      iss_valid <= 2'b00;
      iss_thread <= 2'b00;
      iss_sel0 <= '0;
      iss_sel1 <= '0;
      iss_wide <= 2'b00;
      iss_zero_lu <= 2'b00;
      f_taken0 <= 2'b00;
      f_taken1 <= 2'b00;
      dec_thread <= 1'b0;
      rom_busy <= 1'b0;
      fe_stall <= 1'b0;
    end else begin
      iss_valid <= {g1 || (g0 && swap), g0 && !swap};
      iss_thread <= {(use_x && g1) ? ~ith : ith, ith};
      iss_sel0 <= (g0 && !swap) ? m_sel0 : '0;
      iss_sel1 <= g1 ? m_sel1 : ((g0 && swap) ? m_selx : '0);
      iss_wide <= {(m_w1 && g1) || (m_wx && g0 && swap), m_w0 && g0 && !swap};
      iss_zero_lu <= {g1 && m_sel1[4'(ddf_pkg::DDF_U_ALU)],
        g0 && !swap && m_sel0[4'(ddf_pkg::DDF_U_ALU)]};
      f_taken0 <= dth ? 2'b00 : dec_go;
      f_taken1 <= dth ? dec_go : 2'b00;
      dec_thread <= dth;
      rom_busy <= (rom_cnt_q > 3'd1) || (dec_go[0] && rom_req);
      fe_stall <= byte_block || hold_q || (rom_cnt_q != 3'd0);
    end
  end
endmodule : ddf_frontend

`default_nettype wire

// File: verilog/ddf_pkg.sv
// constants for the two-wide, two-thread decode and issue front end
// assumes a single core clock; fetch supplies predecoded instruction attributes
`default_nettype none

package ddf_pkg;
  localparam int unsigned LONG_INSN_BYTES = 8;
  localparam int unsigned MAX_PREFIXES = 3;
  localparam int unsigned ROM_DELAY_CYCLES = 2;
  localparam int unsigned BYTE_WINDOW_CYCLES = 7;
  localparam int unsigned BYTE_WINDOW_LIMIT = 48;
  localparam int unsigned LINE_BYTES = 16;
  localparam int unsigned LOAD_USE_CYCLES = 0;
  localparam int unsigned SIMD_WIDE_BITS = 128;
  localparam int unsigned FP_NARROW_BITS = 64;

  // execution unit classes carried with each instruction
  typedef enum logic [3:0] {
    DDF_U_ALU, DDF_U_SHIFT, DDF_U_LDST, DDF_U_BIT, DDF_U_JUMP, DDF_U_LEA,
    DDF_U_SIMD_ALU, DDF_U_SHUF, DDF_U_FMUL, DDF_U_DIV, DDF_U_FADD
  } ddf_unit_e;

  // one-hot unit select fields on each issue port
  localparam int unsigned UNIT_BITS = 11;
endpackage : ddf_pkg

`default_nettype wire

// File: verilog/ddf_port_map.sv
// maps an instruction's unit class onto one issue port's unit selects
// assumes the caller has already decided the port
`default_nettype none

module ddf_port_map (
  // request
  input wire logic [3:0] unit,
  input wire logic port1,
  input wire logic simd64,
  input wire logic fadd_load,
  // result
  output logic legal,
  output logic [ddf_pkg::UNIT_BITS-1:0] sel,
  output logic wide
);
  always_comb begin
    sel = '0;
    sel[unit] = 1'b1;
    wide = 1'b0;
    unique case (ddf_pkg::ddf_unit_e'(unit))
      ddf_pkg::DDF_U_ALU, ddf_pkg::DDF_U_SIMD_ALU: begin
        legal = !(port1 && simd64 && unit == 4'(ddf_pkg::DDF_U_SIMD_ALU));
        wide = !simd64 && unit == 4'(ddf_pkg::DDF_U_SIMD_ALU);
      end
      ddf_pkg::DDF_U_SHIFT, ddf_pkg::DDF_U_LDST: begin
        legal = !port1;
      end
      ddf_pkg::DDF_U_BIT, ddf_pkg::DDF_U_JUMP, ddf_pkg::DDF_U_LEA: begin
        legal = port1;
      end
      ddf_pkg::DDF_U_SHUF, ddf_pkg::DDF_U_FMUL, ddf_pkg::DDF_U_DIV: begin
        legal = !port1;
        wide = unit == 4'(ddf_pkg::DDF_U_SHUF);
      end
      ddf_pkg::DDF_U_FADD: begin
        legal = port1 || fadd_load;
      end
      default: begin
        legal = 1'b0;
        sel = '0;
      end
    endcase
  end
endmodule : ddf_port_map

`default_nettype wire

// File: testbench/ddf_props.sv
// concurrent checks on the front end ports
// assumes ddf_pkg is compiled first; bound onto ddf_frontend from the bench
`default_nettype none

module ddf_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fetch, thread 0, and consumption
  input wire logic [7:0] f_unit0,
  input wire logic [9:0] f_len0,
  input wire logic [1:0] f_x870,
  input wire logic [1:0] f_rom0,
  input wire logic [1:0] f_taken0,
  input wire logic [1:0] f_taken1,
  // issue and status
  input wire logic [1:0] iss_valid,
  input wire logic [ddf_pkg::UNIT_BITS-1:0] iss_sel0,
  input wire logic [ddf_pkg::UNIT_BITS-1:0] iss_sel1,
  input wire logic [1:0] iss_wide,
  input wire logic rom_busy,
  input wire logic fe_stall
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // bit, jump, lea never on port 0; shift, load/store, shuffle, mul, div never on port 1
  localparam logic [10:0] NOT_P0 = 11'h038;
  localparam logic [10:0] NOT_P1 = 11'h386;

  sel0_hot_a: assert property (iss_valid[0] |-> $onehot(iss_sel0))
    else $error("port 0 select not one-hot");
  sel1_hot_a: assert property (iss_valid[1] |-> $onehot(iss_sel1))
    else $error("port 1 select not one-hot");
  port0_units_a: assert property (iss_valid[0] |-> (iss_sel0 & NOT_P0) == 11'h000)
    else $error("port 0 selected a port 1 unit");
  port1_units_a: assert property (iss_valid[1] |-> (iss_sel1 & NOT_P1) == 11'h000)
    else $error("port 1 selected a port 0 unit");
  wide_path_a: assert property (iss_wide[1] |-> iss_valid[1] &&
    (iss_sel1[ddf_pkg::DDF_U_SIMD_ALU] || iss_sel1[ddf_pkg::DDF_U_FADD]))
    else $error("wide path on a narrow unit");
  pair_whole_a: assert property (f_taken0[1] |-> f_taken0[0])
    else $error("slot 1 taken alone");
  decode_two_a: assert property ($countones({f_taken0, f_taken1}) <= 2)
    else $error("more than two decoded");
  jump_last_a: assert property (f_taken0[1] |->
    $past(f_unit0[3:0], 2) != ddf_pkg::DDF_U_JUMP)
    else $error("jump paired as first");
  x87_one_a: assert property (f_taken0[1] |-> !(&$past(f_x870, 2)))
    else $error("two x87 in one cycle");
  rom_dec0_a: assert property (f_taken0[1] |-> !(|$past(f_rom0, 2)))
    else $error("rom insn paired");
  long_single_a: assert property (f_taken0[1] |->
    $past(f_len0[9:5], 2) <= 5'(ddf_pkg::LONG_INSN_BYTES))
    else $error("long slot 1 paired");
  rom_delay_a: assert property ($rose(rom_busy) |-> rom_busy[*2] ##1 !rom_busy)
    else $error("rom delay not two cycles");
  stall_hold_a: assert property (fe_stall[*2] |-> f_taken0 == 2'b00)
    else $error("decode during stall");

  cover property (f_taken0 == 2'b11);
  cover property ($rose(rom_busy));
  cover property (fe_stall);
endmodule // ddf_props

`default_nettype wire

// File: testbench/ddf_fetch_model.sv
// fetch buffer model for one thread: queue of predecoded instruction words
// assumes word = {unsafe, load, simd64, rom, x87, pfx[2:0], len[4:0], unit[3:0]}
`default_nettype none

module ddf_fetch_model (
  // clock
  input wire logic clk,
  // slots toward the front end
  output var logic [1:0] valid,
  output var logic [7:0] unit,
  output var logic [9:0] len,
  output var logic [5:0] pfx,
  output var logic [1:0] x87,
  output var logic [1:0] rom,
  output var logic [1:0] simd64,
  output var logic [1:0] load,
  output var logic [1:0] unsafe,
  output var logic [3:0] addr_lo,
  // slots consumed
  input wire logic [1:0] taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] q [$];
  logic [16:0] w0, w1;
  logic [16:0] junk = 17'h0AAAA;
  logic [3:0] addr = 4'h0;
  int pops = 0;

  task automatic push(input logic [16:0] w);
    q.push_back(w);
  endtask

  // empty slots carry a changing pattern, not the last word
  task automatic show();
    w0 = (q.size() > 0) ? q[0] : junk;
    w1 = (q.size() > 1) ? q[1] : ~junk;
    valid = {q.size() > 1, q.size() > 0};
    {unsafe, load, simd64, rom, x87, pfx, len, unit} = {w1[16], w0[16], w1[15], w0[15],
      w1[14], w0[14], w1[13], w0[13], w1[12], w0[12], w1[11:9], w0[11:9], w1[8:4], w0[8:4],
      w1[3:0], w0[3:0]};
    addr_lo = addr;
  endtask

  initial show();
  // slots are held until taken; an untaken slot 1 comes back as slot 0
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (taken[i] === 1'b1 && q.size() > 0) begin
        addr = addr + 4'(q[0][8:4]);
        void'(q.pop_front());
        pops++;
      end
    end
    junk = {junk[15:0], ~junk[16]};
    show();
  end
endmodule // ddf_fetch_model

`default_nettype wire

// File: testbench/tb_dual_decode_issue_frontend.sv
// bench for the dual decode and issue front end, one task per scenario
// assumes ddf_pkg, ddf_frontend, ddf_props and ddf_fetch_model are compiled first
`default_nettype none

module tb_dual_decode_issue_frontend;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
  localparam int TMO = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic prefetch_ready = 1'b1;
  logic [1:0] v0, v1, x0, x1, r0, r1, s0, s1, l0, l1, u0, u1, tk0, tk1, thr;
  logic [7:0] un0, un1;
  logic [9:0] ln0, ln1;
  logic [5:0] px0, px1;
  logic [3:0] a0, a1;
  logic dec_thread, rom_busy, fe_stall;
  logic [1:0] iss_valid, iss_thread, iss_wide, iss_zero_lu;
  logic [ddf_pkg::UNIT_BITS-1:0] iss_sel0, iss_sel1, seen0, seen1;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc, pairs, rom_n, stall_n, issued, b0, b1;

  always #4 clk = ~clk;

  ddf_fetch_model fm0 (.clk(clk), .valid(v0), .unit(un0), .len(ln0), .pfx(px0), .x87(x0),
    .rom(r0), .simd64(s0), .load(l0), .unsafe(u0), .addr_lo(a0), .taken(tk0));
  ddf_fetch_model fm1 (.clk(clk), .valid(v1), .unit(un1), .len(ln1), .pfx(px1), .x87(x1),
    .rom(r1), .simd64(s1), .load(l1), .unsafe(u1), .addr_lo(a1), .taken(tk1));
  ddf_frontend #(.QDEPTH(4)) uut (.clk(clk), .rst_n(rst_n), .f_valid0(v0), .f_valid1(v1),
    .f_unit0(un0), .f_unit1(un1), .f_len0(ln0), .f_len1(ln1), .f_pfx0(px0), .f_pfx1(px1),
    .f_x870(x0), .f_x871(x1), .f_rom0(r0), .f_rom1(r1), .f_simd640(s0), .f_simd641(s1),
    .f_load0(l0), .f_load1(l1), .f_unsafe0(u0), .f_unsafe1(u1), .f_addr_lo0(a0),
    .f_addr_lo1(a1), .prefetch_ready(prefetch_ready), .f_taken0(tk0), .f_taken1(tk1),
    .dec_thread(dec_thread), .iss_valid(iss_valid), .iss_thread(iss_thread),
    .iss_sel0(iss_sel0), .iss_sel1(iss_sel1), .iss_wide(iss_wide),
    .iss_zero_lu(iss_zero_lu), .rom_busy(rom_busy), .fe_stall(fe_stall));

  // event counters read by the scenarios
  always @(posedge clk) begin
    cyc++;
    if (tk0 === 2'b11) pairs++;
    if (rom_busy === 1'b1) rom_n++;
    if (fe_stall === 1'b1) stall_n++;
    for (int p = 0; p < 2; p++) begin
      if (iss_valid[p] === 1'b1) begin
        if (p == 0) seen0 = seen0 | iss_sel0;
        else seen1 = seen1 | iss_sel1;
        thr[iss_thread[p]] = 1'b1;
        issued++;
      end
    end
    if (cyc == TMO) begin
      n_errors++;
      results();
    end
  end

  function automatic logic [16:0] mk(logic [3:0] u, logic [4:0] l, logic [2:0] p,
                                     logic [4:0] f);
    return {f, p, l, u};
  endfunction

  task automatic put(input int t, input logic [16:0] w);
    if (t == 0) fm0.push(w);
    else fm1.push(w);
  endtask

  task automatic clr();
    {pairs, rom_n, stall_n, issued} = '0;
    {seen0, seen1, thr} = '0;
    b0 = fm0.pops;
    b1 = fm1.pops;
  endtask

  task automatic go(input int n0, input int n1, input int ni);
    for (int i = 0; i < 300 && (fm0.pops - b0 < n0 || fm1.pops - b1 < n1 || issued < ni); i++)
      @(negedge clk);
    repeat (4) @(negedge clk);
    `CHK(issued, ni)
  endtask

  task automatic s_pair_jump_x87();
    logic [4:0] f [3] = '{5'h00, 5'h00, 5'h01};
    logic [3:0] u [3] = '{ddf_pkg::DDF_U_ALU, ddf_pkg::DDF_U_JUMP, ddf_pkg::DDF_U_ALU};
    for (int k = 0; k < 3; k++) begin
      clr();
      put(0, mk(u[k], 5'h03, 3'h0, f[k]));
      put(0, mk(ddf_pkg::DDF_U_ALU, 5'h03, 3'h0, f[k]));
      go(2, 0, 2);
      `CHK(pairs, (k == 0) ? 1 : 0)
    end
    clr();
    put(0, mk(ddf_pkg::DDF_U_ALU, 5'h03, 3'h0, 5'h00));
    put(0, mk(ddf_pkg::DDF_U_JUMP, 5'h03, 3'h0, 5'h00));
    go(2, 0, 2);
    `CHK(pairs, 1)
    `CHK(seen1[ddf_pkg::DDF_U_JUMP], 1'b1)
  endtask

  task automatic s_rom();
    logic [16:0] c [4];
    c = '{mk(ddf_pkg::DDF_U_ALU, 5'h03, 3'h0, 5'h02), mk(ddf_pkg::DDF_U_ALU, 5'h09, 3'h0, 5'h00),
      mk(ddf_pkg::DDF_U_ALU, 5'h03, 3'h4, 5'h00), mk(ddf_pkg::DDF_U_ALU, 5'h08, 3'h3, 5'h00)};
    for (int k = 0; k < 4; k++) begin
      clr();
      put(0, mk(ddf_pkg::DDF_U_ALU, 5'h03, 3'h0, 5'h00));
      put(0, c[k]);
      go(2, 0, 2);
      `CHK(pairs, (k == 3) ? 1 : 0)
      `CHK(rom_n, (k == 3) ? 0 : int'(ddf_pkg::ROM_DELAY_CYCLES))
    end
  endtask

  task automatic s_ports();
    logic [3:0] u [9];
    logic [8:0] p1 = 9'h0E0;
    u = '{ddf_pkg::DDF_U_SHIFT, ddf_pkg::DDF_U_LDST, ddf_pkg::DDF_U_SHUF, ddf_pkg::DDF_U_FMUL,
      ddf_pkg::DDF_U_DIV, ddf_pkg::DDF_U_BIT, ddf_pkg::DDF_U_LEA, ddf_pkg::DDF_U_FADD,
      ddf_pkg::DDF_U_SIMD_ALU};
    for (int k = 0; k < 9; k++) begin
      clr();
      put(0, mk(u[k], 5'h03, 3'h0, (k == 8) ? 5'h04 : 5'h00));
      go(1, 0, 1);
      `CHK(seen1[u[k]], p1[k])
      `CHK(seen0[u[k]], ~p1[k])
    end
  endtask

  task automatic s_threads();
    clr();
    for (int k = 0; k < 4; k++) begin
      put(0, mk(ddf_pkg::DDF_U_ALU, 5'h02, 3'h0, 5'h00));
      put(1, mk(ddf_pkg::DDF_U_LEA, 5'h02, 3'h0, 5'h00));
    end
    go(4, 4, 8);
    `CHK(thr, 2'b11)
  endtask

  task automatic s_bytes();
    int pad [2];
    int n [2];
    prefetch_ready = 1'b0;
    clr();
    pad[0] = (16 - int'(fm0.addr)) % 16;
    pad[1] = (16 - int'(fm1.addr)) % 16;
    // up to two aligning instructions first, so both threads then pair without line crossings
    for (int t = 0; t < 2; t++) begin
      n[t] = 0;
      if (pad[t] > 0) begin
        put(t, mk(ddf_pkg::DDF_U_ALU, 5'((pad[t] + 1) / 2), 3'h0, 5'h00));
        n[t]++;
      end
      if (pad[t] > 1) begin
        put(t, mk(ddf_pkg::DDF_U_ALU, 5'(pad[t] / 2), 3'h0, 5'h00));
        n[t]++;
      end
      for (int k = 0; k < 12; k++) put(t, mk(ddf_pkg::DDF_U_ALU, 5'h08, 3'h0, 5'h00));
    end
    repeat (40) @(negedge clk);
    `CHK(stall_n != 0, 1'b1)
    prefetch_ready = 1'b1;
    go(12 + n[0], 12 + n[1], 24 + n[0] + n[1]);
    `CHK(fm0.pops - b0 + fm1.pops - b1, 24 + n[0] + n[1])
  endtask

  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    s_pair_jump_x87();
    s_rom();
    s_ports();
    s_threads();
    s_bytes();
    results();
  end
endmodule // tb_dual_decode_issue_frontend

bind ddf_frontend ddf_props u_props (.clk, .rst_n, .f_unit0, .f_len0, .f_x870, .f_rom0,
  .f_taken0, .f_taken1, .iss_valid, .iss_sel0, .iss_sel1, .iss_wide, .rom_busy, .fe_stall);

`default_nettype wire
